// File: hdl/csb_params.svh
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CSB_OFS_INDIRECT 6'h00
`define CSB_OFS_PC_LOW 6'h02
`define CSB_OFS_ALU_FLAGS 6'h03
`define CSB_OFS_FILE_SEL 6'h04
`define CSB_OFS_PORT 6'h06
`define CSB_OFS_POWER 6'h08
`define CSB_OFS_WAKE 6'h09
`define CSB_OFS_PC_HIGH 6'h0a
`define CSB_OFS_PULL_LOW 6'h0b
`define CSB_OFS_PULL_HIGH 6'h0c
`define CSB_OFS_IRQ_EN 6'h0e
`define CSB_OFS_IRQ_FLAG 6'h0f
`define CSB_OFS_GPR 6'h10

// ****************************************************************
// reset values
// ****************************************************************
`define CSB_RST_PC 10'h000
`define CSB_RST_ALU_FLAGS 8'h18
`define CSB_RST_FILE_SEL 8'h00
`define CSB_RST_PORT 8'h00
`define CSB_RST_POWER 8'h88
`define CSB_RST_WAKE 8'h3f
`define CSB_RST_PC_HIGH 8'h00
`define CSB_RST_PULL_LOW 8'hff
`define CSB_RST_PULL_HIGH 8'h3f
`define CSB_RST_IRQ_EN 8'h00
`define CSB_RST_IRQ_FLAG 8'h00

// ****************************************************************
// field positions and masks
// ****************************************************************
`define CSB_BIT_CARRY 0
`define CSB_BIT_HALF_CARRY 1
`define CSB_BIT_ZERO 2
`define CSB_BIT_POWER_DOWN 3
`define CSB_BIT_TIMEOUT 4
`define CSB_BIT_LVR_EN 3
`define CSB_BIT_EXT_IRQ_SEL 6
`define CSB_BIT_WDT_EN 7
`define CSB_BIT_SPEEDUP_STOP 7
`define CSB_MASK_WAKE 8'h3f
`define CSB_MASK_PC_HIGH 8'h7f
`define CSB_MASK_PULL_LOW 8'hf0
`define CSB_MASK_PULL_HIGH 8'h3f
`define CSB_MASK_IRQ 8'h4f

`endif

// File: hdl/csb_pkg.sv
package csb_pkg;

    // ****************************************************************
    // instruction kinds as seen by the program counter
    // ****************************************************************
    typedef enum logic [2:0] {
        CSB_INSTR_SEQ = 3'b000,
        CSB_INSTR_SHORT_JUMP = 3'b001,
        CSB_INSTR_SHORT_CALL = 3'b010,
        CSB_INSTR_LONG_JUMP = 3'b011,
        CSB_INSTR_LONG_CALL = 3'b100
    } csb_instr_kind_t;

    typedef struct packed {
        logic valid;
        csb_instr_kind_t kind;
        logic [9:0] target;
    } csb_instr_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } csb_sfr_req_t;

    typedef struct packed {
        logic upd_c;
        logic upd_hc;
        logic upd_z;
        logic carry;
        logic half_carry;
        logic zero;
    } csb_alu_t;

    typedef struct packed {
        logic sleep_exec;
        logic clrwdt_exec;
        logic wdt_timeout;
        logic [7:0] irq_set;
    } csb_event_t;

    typedef struct packed {
        logic [7:0] port_latch;
        logic ext_irq_pin_select;
        logic [5:0] pin_wake_enable;
        logic [3:0] pull_low_disable_n;
        logic [5:0] pull_high_disable_n;
    } csb_pin_ctl_t;

endpackage

// File: hdl/csb_core_sfr_bank.sv
`include "csb_params.svh"

// Summary of operation
// - ten-bit counter steps after each plain instruction
// - upper bits: buffer on low write, word on long jump/call
// - short jump: bits 8..0 word, 9 buffer
// - short call: low byte word, buffer high, push
// - long jump loads all ten bits from word
// - long call loads ten bits, pushes next address
// - carry set on carry or no borrow
// - half carry tracks bit three carry/borrow
// - zero flag set when result is zero
// - power-down set by reset/watchdog clear, sleep clears
// - timeout set by reset/clear/sleep, watchdog timeout clears
// - pointer low six bits select; bank bits ignored
// - port read: pins, or latch per option
// - port write fills latches; top bits plain
// - select bit routes pin zero to interrupt
// - six wake enables, all set after reset
// - writing one stops crystal speed-up
// - pull-low controls active low, reset disabled
// - pull-high controls active low, reset disabled
// - enable bits gate five interrupt sources
// - indirect register accesses pointed location
// - flags cleared by software, masked read zero
module csb_core_sfr_bank
    import csb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // cpu core side
    input wire csb_instr_t instr,
    input wire csb_sfr_req_t sfr_req,
    input wire csb_alu_t alu,
    input wire csb_event_t events,
    // pin side
    input wire logic [5:0] pin_level,
    input wire logic [5:0] pin_is_input,
    input wire logic output_readback_option,
    // program counter and stack
    output logic [9:0] pc,
    output logic push_valid,
    output logic [9:0] push_addr,
    // read answer
    output logic rd_valid,
    output logic [7:0] rd_data,
    // control outputs
    output csb_pin_ctl_t pin_ctl,
    output logic watchdog_enable_bit,
    output logic low_voltage_reset_enable,
    output logic crystal_speedup_stop,
    output logic [7:0] irq_active
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] alu_status_flags;
    logic [7:0] file_select_pointer;
    logic [7:0] port_data;
    logic [7:0] power_control;
    logic [7:0] pin_wakeup_control;
    logic [7:0] program_counter_high_buffer;
    logic [7:0] pull_low_control;
    logic [7:0] pull_high_control;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] irq_flag;
    logic [7:0] gpr [0:47];
    logic [5:0] eff;
    logic [7:0] next_irq_flag;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [5:0] eff_addr(input logic [5:0] a, input logic [7:0] sel);
        eff_addr = (a == `CSB_OFS_INDIRECT) ? sel[5:0] : a;
    endfunction

    function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [5:0] lvl,
                                             input logic [5:0] inp, input logic opt);
        logic [7:0] v;
        v = latch;
        for (int i = 0; i < 6; i++) begin
            v[i] = (inp[i] || !opt) ? lvl[i] : latch[i];
        end
        return v;
    endfunction

    function automatic logic wr_at(input csb_sfr_req_t r, input logic [5:0] e,
                                   input logic [5:0] a);
        wr_at = r.wr && (e == a);
    endfunction

    assign eff = eff_addr(sfr_req.addr, file_select_pointer);

    // ****************************************************************
    // program counter and stack push
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc <= `CSB_RST_PC;
        end else if (wr_at(sfr_req, eff, `CSB_OFS_PC_LOW)) begin
            pc <= {program_counter_high_buffer[1:0], sfr_req.wdata};
        end else if (instr.valid) begin
            case (instr.kind)
                CSB_INSTR_SHORT_JUMP: pc <= {program_counter_high_buffer[1], instr.target[8:0]};
                CSB_INSTR_SHORT_CALL: pc <= {program_counter_high_buffer[1:0], instr.target[7:0]};
                CSB_INSTR_LONG_JUMP: pc <= instr.target;
                CSB_INSTR_LONG_CALL: pc <= instr.target;
                default: pc <= pc + 10'h001;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            push_valid <= 1'b0;
            push_addr <= `CSB_RST_PC;
        end else begin
            push_valid <= instr.valid && (instr.kind == CSB_INSTR_SHORT_CALL ||
                                          instr.kind == CSB_INSTR_LONG_CALL);
            push_addr <= pc + 10'h001;
        end
    end

    // ****************************************************************
    // alu status and reset cause flags
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alu_status_flags <= `CSB_RST_ALU_FLAGS;
        end else begin
            if (wr_at(sfr_req, eff, `CSB_OFS_ALU_FLAGS)) begin
                alu_status_flags <= sfr_req.wdata;
            end
            if (alu.upd_c) begin
                alu_status_flags[`CSB_BIT_CARRY] <= alu.carry;
            end
            if (alu.upd_hc) begin
                alu_status_flags[`CSB_BIT_HALF_CARRY] <= alu.half_carry;
            end
            if (alu.upd_z) begin
                alu_status_flags[`CSB_BIT_ZERO] <= alu.zero;
            end
            if (events.clrwdt_exec) begin
                alu_status_flags[`CSB_BIT_POWER_DOWN] <= 1'b1;
            end else if (events.sleep_exec) begin
                alu_status_flags[`CSB_BIT_POWER_DOWN] <= 1'b0;
            end
            if (events.wdt_timeout) begin
                alu_status_flags[`CSB_BIT_TIMEOUT] <= 1'b0;
            end else if (events.clrwdt_exec || events.sleep_exec) begin
                alu_status_flags[`CSB_BIT_TIMEOUT] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // pointer, port latch and pin controls
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            file_select_pointer <= `CSB_RST_FILE_SEL;
            port_data <= `CSB_RST_PORT;
        end else begin
            if (wr_at(sfr_req, eff, `CSB_OFS_FILE_SEL)) begin
                file_select_pointer <= sfr_req.wdata;
            end
            if (wr_at(sfr_req, eff, `CSB_OFS_PORT)) begin
                port_data <= sfr_req.wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            power_control <= `CSB_RST_POWER;
            pin_wakeup_control <= `CSB_RST_WAKE;
            pull_low_control <= `CSB_RST_PULL_LOW;
            pull_high_control <= `CSB_RST_PULL_HIGH;
            interrupt_enable_mask <= `CSB_RST_IRQ_EN;
        end else begin
            if (wr_at(sfr_req, eff, `CSB_OFS_POWER)) begin
                power_control <= sfr_req.wdata;
            end
            if (wr_at(sfr_req, eff, `CSB_OFS_WAKE)) begin
                pin_wakeup_control <= sfr_req.wdata & `CSB_MASK_WAKE;
            end
            if (wr_at(sfr_req, eff, `CSB_OFS_PULL_LOW)) begin
                pull_low_control <= sfr_req.wdata | ~`CSB_MASK_PULL_LOW;
            end
            if (wr_at(sfr_req, eff, `CSB_OFS_PULL_HIGH)) begin
                pull_high_control <= sfr_req.wdata & `CSB_MASK_PULL_HIGH;
            end
            if (wr_at(sfr_req, eff, `CSB_OFS_IRQ_EN)) begin
                interrupt_enable_mask <= sfr_req.wdata & `CSB_MASK_IRQ;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            program_counter_high_buffer <= `CSB_RST_PC_HIGH;
            crystal_speedup_stop <= 1'b0;
        end else begin
            if (wr_at(sfr_req, eff, `CSB_OFS_PC_HIGH)) begin
                program_counter_high_buffer <= sfr_req.wdata & `CSB_MASK_PC_HIGH;
            end
            crystal_speedup_stop <= wr_at(sfr_req, eff, `CSB_OFS_PC_HIGH) &&
                                    sfr_req.wdata[`CSB_BIT_SPEEDUP_STOP];
        end
    end

    always_ff @(posedge mclk) begin
        pin_ctl.port_latch <= port_data;
        pin_ctl.ext_irq_pin_select <= power_control[`CSB_BIT_EXT_IRQ_SEL];
        pin_ctl.pin_wake_enable <= pin_wakeup_control[5:0];
        pin_ctl.pull_low_disable_n <= pull_low_control[7:4];
        pin_ctl.pull_high_disable_n <= pull_high_control[5:0];
        watchdog_enable_bit <= power_control[`CSB_BIT_WDT_EN];
        low_voltage_reset_enable <= power_control[`CSB_BIT_LVR_EN];
        if (!rst_n) begin
            pin_ctl.port_latch <= `CSB_RST_PORT;
            pin_ctl.ext_irq_pin_select <= 1'(`CSB_RST_POWER >> `CSB_BIT_EXT_IRQ_SEL);
            pin_ctl.pin_wake_enable <= 6'(`CSB_RST_WAKE);
            pin_ctl.pull_low_disable_n <= 4'(`CSB_RST_PULL_LOW >> 4);
            pin_ctl.pull_high_disable_n <= 6'(`CSB_RST_PULL_HIGH);
            watchdog_enable_bit <= 1'(`CSB_RST_POWER >> `CSB_BIT_WDT_EN);
            low_voltage_reset_enable <= 1'(`CSB_RST_POWER >> `CSB_BIT_LVR_EN);
        end
    end

    // ****************************************************************
    // interrupt flags
    // ****************************************************************
    always_comb begin
        next_irq_flag = irq_flag;
        if (wr_at(sfr_req, eff, `CSB_OFS_IRQ_FLAG)) begin
            next_irq_flag = sfr_req.wdata & `CSB_MASK_IRQ;
        end
        next_irq_flag = next_irq_flag | (events.irq_set & `CSB_MASK_IRQ);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_flag <= `CSB_RST_IRQ_FLAG;
            irq_active <= `CSB_RST_IRQ_FLAG;
        end else begin
            irq_flag <= next_irq_flag;
            irq_active <= irq_flag & interrupt_enable_mask;
        end
    end

    // ****************************************************************
    // general purpose file
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (sfr_req.wr && eff >= `CSB_OFS_GPR) begin
            gpr[eff - `CSB_OFS_GPR] <= sfr_req.wdata;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_valid <= sfr_req.rd;
            if (eff >= `CSB_OFS_GPR) begin
                rd_data <= gpr[eff - `CSB_OFS_GPR];
            end else begin
                case (eff)
                    `CSB_OFS_PC_LOW: rd_data <= pc[7:0];
                    `CSB_OFS_ALU_FLAGS: rd_data <= alu_status_flags;
                    `CSB_OFS_FILE_SEL: rd_data <= file_select_pointer;
                    `CSB_OFS_PORT: rd_data <= port_view(port_data, pin_level, pin_is_input,
                                                        output_readback_option);
                    `CSB_OFS_POWER: rd_data <= power_control;
                    `CSB_OFS_WAKE: rd_data <= pin_wakeup_control;
                    `CSB_OFS_PC_HIGH: rd_data <= program_counter_high_buffer;
                    `CSB_OFS_PULL_LOW: rd_data <= pull_low_control;
                    `CSB_OFS_PULL_HIGH: rd_data <= pull_high_control;
                    `CSB_OFS_IRQ_EN: rd_data <= interrupt_enable_mask;
                    `CSB_OFS_IRQ_FLAG: rd_data <= irq_flag & interrupt_enable_mask;
                    default: rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_plain_step;
        instr.valid && instr.kind == CSB_INSTR_SEQ && !wr_at(sfr_req, eff, `CSB_OFS_PC_LOW);
    endsequence

    sequence s_call_taken;
        instr.valid && !wr_at(sfr_req, eff, `CSB_OFS_PC_LOW) &&
        (instr.kind == CSB_INSTR_SHORT_CALL || instr.kind == CSB_INSTR_LONG_CALL);
    endsequence

    a_pc_plain_step: assert property (s_plain_step |=> pc == $past(pc) + 10'h001)
        else $error("counter did not step by one");

    a_pc_low_write: assert property (wr_at(sfr_req, eff, `CSB_OFS_PC_LOW) |=>
        pc == {$past(program_counter_high_buffer[1:0]), $past(sfr_req.wdata)})
        else $error("low byte write did not load counter");

    a_short_jump_load: assert property (
        instr.valid && instr.kind == CSB_INSTR_SHORT_JUMP &&
        !wr_at(sfr_req, eff, `CSB_OFS_PC_LOW) |=> pc[8:0] == $past(instr.target[8:0]) &&
        pc[9] == $past(program_counter_high_buffer[1]))
        else $error("short jump load wrong");

    a_call_push_addr: assert property (s_call_taken |=> push_valid &&
        push_addr == $past(pc) + 10'h001)
        else $error("call did not push next address");

    a_long_jump_load: assert property (instr.valid &&
        !wr_at(sfr_req, eff, `CSB_OFS_PC_LOW) &&
        (instr.kind == CSB_INSTR_LONG_JUMP || instr.kind == CSB_INSTR_LONG_CALL) |=>
        pc == $past(instr.target))
        else $error("long load wrong");

    a_carry_flag: assert property (alu.upd_c |=> alu_status_flags[0] == $past(alu.carry))
        else $error("carry flag not updated");

    a_zero_flag: assert property (alu.upd_z |=> alu_status_flags[2] == $past(alu.zero))
        else $error("zero flag not updated");

    a_sleep_flags: assert property (events.sleep_exec && !events.clrwdt_exec &&
        !events.wdt_timeout |=> !alu_status_flags[3] && alu_status_flags[4])
        else $error("sleep flags wrong");

    a_timeout_clear: assert property (events.wdt_timeout |=> !alu_status_flags[4])
        else $error("timeout flag not cleared");

    a_flag_masked: assert property (sfr_req.rd && eff == `CSB_OFS_IRQ_FLAG |=>
        rd_valid && (rd_data & ~$past(interrupt_enable_mask)) == 8'h00)
        else $error("masked flag read as one");

    a_flag_set_wins: assert property (events.irq_set[0] |=>
        irq_flag[0] ##1 irq_active[0] == $past(interrupt_enable_mask[0]))
        else $error("flag event lost");

    a_speedup_pulse: assert property (crystal_speedup_stop |->
        $past(wr_at(sfr_req, eff, `CSB_OFS_PC_HIGH) && sfr_req.wdata[`CSB_BIT_SPEEDUP_STOP]))
        else $error("speed-up stop without write");

endmodule

// File: testbench/csb_cpu_model.sv
module csb_cpu_model
    import csb_pkg::*;
(
    // clock
    input wire logic mclk,
    // core side requests
    output csb_instr_t instr,
    output csb_sfr_req_t sfr_req,
    output csb_alu_t alu,
    output csb_event_t events
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // idle state
    // ****************************************************************
    initial begin
        instr = '0;
        sfr_req = '0;
        alu = '0;
        events = '0;
    end

    // ****************************************************************
    // one-cycle requests, launched at the falling edge
    // ****************************************************************
    task automatic access(input logic r, input logic w, input logic [5:0] a,
                          input logic [7:0] d);
        @(negedge mclk);
        sfr_req = '{rd: r, wr: w, addr: a, wdata: d};
        @(negedge mclk);
        sfr_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic exec(input csb_instr_kind_t k, input logic [9:0] t);
        @(negedge mclk);
        instr = '{valid: 1'b1, kind: k, target: t};
        @(negedge mclk);
        instr = '0;
    endtask

    task automatic strobe(input logic [5:0] a, input logic [10:0] e);
        @(negedge mclk);
        alu = a;
        events = e;
        @(negedge mclk);
        alu = '0;
        events = '0;
    endtask
endmodule

// File: testbench/test_core_sfr_bank.sv
`include "csb_params.svh"

module test_core_sfr_bank
    import csb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk;
    logic rst_n;
    csb_instr_t instr;
    csb_sfr_req_t sfr_req;
    csb_alu_t alu;
    csb_event_t events;
    logic [5:0] pin_level;
    logic [5:0] pin_is_input;
    logic output_readback_option;
    logic [9:0] pc;
    logic push_valid;
    logic [9:0] push_addr;
    logic rd_valid;
    logic [7:0] rd_data;
    csb_pin_ctl_t pin_ctl;
    logic watchdog_enable_bit;
    logic low_voltage_reset_enable;
    logic crystal_speedup_stop;
    logic [7:0] irq_active;
    logic seen;
    int fail_count = 0;
    int check_count = 0;
    logic [5:0] ra [7] = '{6'h02, 6'h03, 6'h08, 6'h09, 6'h0b, 6'h0c, 6'h0e};
    logic [7:0] rv [7] = '{8'h00, 8'h18, 8'h88, 8'h3f, 8'hff, 8'h3f, 8'h00};

    // ****************************************************************
    // design and core model
    // ****************************************************************
    csb_core_sfr_bank u_csb_core_sfr_bank (.mclk(mclk), .rst_n(rst_n), .instr(instr),
        .sfr_req(sfr_req), .alu(alu), .events(events), .pin_level(pin_level),
        .pin_is_input(pin_is_input), .output_readback_option(output_readback_option),
        .pc(pc), .push_valid(push_valid), .push_addr(push_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .pin_ctl(pin_ctl), .watchdog_enable_bit(watchdog_enable_bit),
        .low_voltage_reset_enable(low_voltage_reset_enable),
        .crystal_speedup_stop(crystal_speedup_stop), .irq_active(irq_active));

    csb_cpu_model u_cpu (.mclk(mclk), .instr(instr), .sfr_req(sfr_req), .alu(alu),
        .events(events));

    always #4 mclk = ~mclk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        u_cpu.access(1'b1, 1'b0, a, 8'h00);
        chk(32'({rd_valid, rd_data}), 32'({1'b1, exp}));
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_cpu.access(1'b0, 1'b1, a, d);
    endtask

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_of_test;
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        seen = 1'b0;
        pin_level = 6'h0a;
        pin_is_input = 6'h0f;
        output_readback_option = 1'b1;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        // reset values
        for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
        chk(32'(pin_ctl), 32'({8'h00, 1'b0, 6'h3f, 4'hf, 6'h3f}));
        chk(32'({watchdog_enable_bit, low_voltage_reset_enable}), 32'h3);
        // power control and pin controls
        wr(`CSB_OFS_POWER, 8'h48);
        @(negedge mclk);
        chk(32'({pin_ctl.ext_irq_pin_select, watchdog_enable_bit, low_voltage_reset_enable}),
            32'h5);
        rd_chk(`CSB_OFS_POWER, 8'h48);
        wr(`CSB_OFS_PULL_LOW, 8'h00);
        rd_chk(`CSB_OFS_PULL_LOW, 8'h0f);
        wr(`CSB_OFS_PULL_HIGH, 8'h30);
        rd_chk(`CSB_OFS_PULL_HIGH, 8'h30);
        wr(`CSB_OFS_WAKE, 8'hc5);
        rd_chk(`CSB_OFS_WAKE, 8'h05);
        chk(32'({pin_ctl.pin_wake_enable, pin_ctl.pull_low_disable_n}), 32'h50);
        chk(32'(pin_ctl.pull_high_disable_n), 32'h30);
        wr(6'h05, 8'hff);
        rd_chk(6'h05, 8'h00);
        // port data
        wr(`CSB_OFS_PORT, 8'hff);
        rd_chk(`CSB_OFS_PORT, 8'hfa);
        output_readback_option = 1'b0;
        rd_chk(`CSB_OFS_PORT, 8'hca);
        chk(32'(pin_ctl.port_latch), 32'hff);
        // program counter loading
        wr(`CSB_OFS_PC_HIGH, 8'h82);
        seen = crystal_speedup_stop;
        @(negedge mclk);
        seen = seen | crystal_speedup_stop;
        chk(32'(seen), 32'h1);
        rd_chk(`CSB_OFS_PC_HIGH, 8'h02);
        u_cpu.exec(CSB_INSTR_SHORT_JUMP, 10'h155);
        chk(32'(pc), 32'h355);
        u_cpu.exec(CSB_INSTR_SHORT_CALL, 10'h1aa);
        chk(32'({push_valid, push_addr, pc}), 32'({1'b1, 10'h356, 10'h2aa}));
        u_cpu.exec(CSB_INSTR_LONG_JUMP, 10'h123);
        chk(32'({push_valid, pc}), 32'h123);
        u_cpu.exec(CSB_INSTR_LONG_CALL, 10'h001);
        chk(32'({push_valid, push_addr, pc}), 32'({1'b1, 10'h124, 10'h001}));
        u_cpu.exec(CSB_INSTR_SEQ, 10'h3ff);
        chk(32'(pc), 32'h002);
        rd_chk(`CSB_OFS_PC_LOW, 8'h02);
        wr(`CSB_OFS_PC_LOW, 8'h40);
        chk(32'(pc), 32'h240);
        // status flags
        u_cpu.strobe(6'b111101, 11'h000);
        rd_chk(`CSB_OFS_ALU_FLAGS, 8'h1d);
        u_cpu.strobe(6'b111010, 11'h000);
        rd_chk(`CSB_OFS_ALU_FLAGS, 8'h1a);
        u_cpu.strobe(6'b000000, 11'h400);
        rd_chk(`CSB_OFS_ALU_FLAGS, 8'h12);
        u_cpu.strobe(6'b000000, 11'h100);
        rd_chk(`CSB_OFS_ALU_FLAGS, 8'h02);
        u_cpu.strobe(6'b000000, 11'h200);
        rd_chk(`CSB_OFS_ALU_FLAGS, 8'h1a);
        // indirect access
        wr(`CSB_OFS_FILE_SEL, 8'hd0);
        wr(`CSB_OFS_INDIRECT, 8'h5a);
        rd_chk(`CSB_OFS_GPR, 8'h5a);
        rd_chk(`CSB_OFS_INDIRECT, 8'h5a);
        // interrupt enables and flags
        wr(`CSB_OFS_IRQ_EN, 8'h44);
        u_cpu.strobe(6'b000000, 11'h04f);
        @(negedge mclk);
        chk(32'(irq_active), 32'h44);
        rd_chk(`CSB_OFS_IRQ_FLAG, 8'h44);
        wr(`CSB_OFS_IRQ_FLAG, 8'h00);
        @(negedge mclk);
        chk(32'(irq_active), 32'h00);
        end_of_test;
    end
endmodule
